// File: rtl/ubsp_defines.vh
`ifndef UBSP_DEFINES_VH
`define UBSP_DEFINES_VH
// configuration modes
`define UBSP_MODE_ZERO   2'h0
`define UBSP_MODE_ONE    2'h1
`define UBSP_MODE_TWO    2'h2
`define UBSP_MODE_THREE  2'h3
// function select
`define UBSP_FN_NONE     2'h0
`define UBSP_FN_MASTER   2'h1
`define UBSP_FN_SLAVE    2'h2
`define UBSP_FN_I2C      2'h3
// data widths
`define UBSP_W_SINGLE    2'h0
`define UBSP_W_DUAL      2'h1
`define UBSP_W_QUAD      2'h2
// timing counts in operating-clock periods; sck half-period exponent cap
`define UBSP_SS_SETUP    25
`define UBSP_SS_HOLD     880
`define UBSP_BYTE_GAP    6
`define UBSP_MAX_EXP     4'h8
`endif

// File: rtl/ubsp_sync.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser for pin inputs
// ----------------------------------------
module ubsp_sync
#(
    parameter W = 1
)
(
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// File: rtl/ubsp_port.v
// Contract
// [RQ1] straps pick one of four modes
// [RQ2] mode sets number of host interfaces
// [RQ3] slave pins only in modes 00, 11
// [RQ4] up to four selects replace gpio pins; code puts only selects 1..3 on gpio0..2
// [RQ5] gpio control ignored on alternate pins
// [RQ6] exactly one of master, slave, i2c
// [RQ7] bus and role come from host init
// [RQ8] miso is input or data bit 1
// [RQ9] mosi is output or data bit 0
// [RQ10] extra pins carry bits 2, 3 in quad
// [RQ11] slave select input held high as master
// [RQ12] single full duplex; dual/quad one way
// [RQ13] dual/quad only as master
// [RQ14] four cpol/cpha modes; cpol sets idle
// [RQ15] cpha chooses two transfer formats
// [RQ16] both sides share cpol/cpha
// [RQ17] sck high/low each 2^n clocks
// [RQ18] external master drives select to us
// [RQ19] select leads first sck by 25 clocks
// [RQ20] select holds 880 clocks after last sck
// [RQ21] master byte gap 6; slave accepts none
// [RQ22] cpha0 sample leading, cpha1 trailing
`timescale 1ns/10ps
`default_nettype none
`include "ubsp_defines.vh"
module ubsp_port
(
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       cfg_strap_hi_i,
    input  wire       cfg_strap_lo_i,
    input  wire       init_i,
    input  wire [1:0] init_func_i,
    input  wire [1:0] init_width_i,
    input  wire       init_cpol_i,
    input  wire       init_cpha_i,
    input  wire [3:0] init_exp_i,
    input  wire [1:0] xfer_ss_i,
    input  wire       xfer_start_i,
    input  wire       xfer_dir_out_i,
    input  wire       xfer_last_i,
    input  wire [7:0] tx_data_i,
    input  wire [3:0] gpio_out_i,
    input  wire [3:0] gpio_oe_i,
    input  wire [3:0] gpio_pin_i,
    input  wire       sck_pin_i,
    input  wire       ss_pin_i,
    input  wire [3:0] io_pin_i,
    output reg  [1:0] cfg_mode_o,
    output reg  [2:0] data_ifs_o,
    output reg        gpio_if_o,
    output reg  [1:0] func_o,
    output reg        busy_o,
    output reg        byte_done_o,
    output reg  [7:0] rx_data_o,
    output reg  [3:0] gpio_in_o,
    output reg        sck_o,
    output reg        sck_oe_o,
    output reg  [3:0] io_o,
    output reg  [3:0] io_oe_o,
    output reg        slave_select_out_0_o,
    output reg  [3:0] gpio_o,
    output reg  [3:0] gpio_oe_o
);
    // ----------------------------------------
    // constants and state
    // ----------------------------------------
    localparam ST_IDLE  = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_BITS  = 3'h2;
    localparam ST_GAP   = 3'h3;
    localparam ST_HOLD  = 3'h4;

    reg  [1:0]  mode;
    reg  [1:0]  strap_taken;
    reg  [1:0]  func;
    reg  [1:0]  width;
    reg         cpol;
    reg         cpha;
    reg  [3:0]  exp_n;
    reg  [2:0]  state;
    reg  [9:0]  tcnt;
    reg  [8:0]  hcnt;
    reg  [3:0]  bcnt;
    reg         phase;
    reg  [7:0]  sh_tx;
    reg  [7:0]  sh_rx;
    reg  [1:0]  sel;
    reg         dir_out;
    reg         last;
    reg  [3:0]  ss_n;
    wire [1:0]  straps_s;
    wire [3:0]  gpio_s;
    wire [3:0]  io_s;
    wire        sck_s;
    wire        sss_n;
    reg         sck_d;
    reg  [2:0]  sbit;
    wire        is_master;
    wire        is_slave;
    wire        is_i2c;
    wire [3:0]  steps;
    wire [8:0]  half;
    reg  [3:0]  alt;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    ubsp_sync #(.W(12)) u_sync
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({cfg_strap_hi_i, cfg_strap_lo_i, gpio_pin_i, io_pin_i,
                 sck_pin_i, ss_pin_i}),
        .q_o   ({straps_s, gpio_s, io_s, sck_s, sss_n})
    );

    // shift steps per byte by width
    function [3:0] steps_of;
        input [1:0] w;
        begin
            case (w)
                `UBSP_W_DUAL: steps_of = 4'h4;
                `UBSP_W_QUAD: steps_of = 4'h2;
                default:      steps_of = 4'h8;
            endcase
        end
    endfunction

    assign is_master = (func == `UBSP_FN_MASTER);
    assign is_slave  = (func == `UBSP_FN_SLAVE);
    assign is_i2c    = (func == `UBSP_FN_I2C);
    assign steps     = steps_of(width);
    assign half      = 9'h001 << exp_n;  // [RQ17]

    // ----------------------------------------
    // strap capture and host init
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode        <= `UBSP_MODE_ZERO;
            strap_taken <= 2'h0;
            func        <= `UBSP_FN_NONE;
            width       <= `UBSP_W_SINGLE;
            cpol        <= 1'b0;
            cpha        <= 1'b0;
            exp_n       <= 4'h0;
        end
        else
        begin
            if (strap_taken != 2'h3)
            begin
                mode        <= straps_s;  // [RQ1]
                strap_taken <= strap_taken + 2'h1;
            end
            if (init_i && state == ST_IDLE)
            begin
                func  <= init_func_i;  // [RQ6] [RQ7]
                if (init_func_i == `UBSP_FN_SLAVE &&
                    (mode == `UBSP_MODE_ONE || mode == `UBSP_MODE_TWO))
                    func <= `UBSP_FN_NONE;  // [RQ3]
                if (init_func_i == `UBSP_FN_MASTER)
                    width <= init_width_i;  // [RQ12]
                else
                    width <= `UBSP_W_SINGLE;  // [RQ13]
                cpol  <= init_cpol_i;  // [RQ14] [RQ16]
                cpha  <= init_cpha_i;  // [RQ15] [RQ16]
                exp_n <= (init_exp_i > `UBSP_MAX_EXP) ? `UBSP_MAX_EXP
                                                      : init_exp_i;
            end
        end
    end

    // ----------------------------------------
    // master engine and slave receive
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state       <= ST_IDLE;
            tcnt        <= 10'h000;
            hcnt        <= 9'h000;
            bcnt        <= 4'h0;
            phase       <= 1'b0;
            sh_tx       <= 8'h00;
            sh_rx       <= 8'h00;
            sel         <= 2'h0;
            dir_out     <= 1'b1;
            last        <= 1'b0;
            ss_n        <= 4'hF;
            sck_o       <= 1'b0;
            byte_done_o <= 1'b0;
            rx_data_o   <= 8'h00;
            sck_d       <= 1'b0;
            sbit        <= 3'h0;
        end
        else
        begin
            byte_done_o <= 1'b0;
            sck_d       <= sck_s;
            if (tcnt == 10'h000 && (state == ST_GAP || state == ST_HOLD))
            begin
                byte_done_o <= 1'b1;
                rx_data_o   <= sh_rx;
            end
            case (state)
                ST_IDLE:
                begin
                    sck_o <= cpol;  // [RQ14]
                    if (is_slave)
                    begin
                        // slave: full duplex single, no gap needed
                        if (sss_n)  // [RQ18]
                        begin
                            sbit  <= 3'h0;
                            sh_tx <= tx_data_i;
                        end
                        else if ((sck_s != sck_d) &&
                                 ((sck_s ^ cpol) == ~cpha))  // [RQ22]
                        begin
                            sh_rx <= {sh_rx[6:0], io_s[0]};  // [RQ9]
                            sbit  <= sbit + 3'h1;
                            if (sbit == 3'h7)  // [RQ21]
                            begin
                                rx_data_o   <= {sh_rx[6:0], io_s[0]};
                                byte_done_o <= 1'b1;
                            end
                        end
                        else if (sck_s != sck_d)
                        begin
                            if (!(cpha == 1'b1 && sbit == 3'h0 &&
                                  (sck_s ^ cpol)))
                                sh_tx <= (sbit == 3'h0 && !cpha) ?
                                         tx_data_i : {sh_tx[6:0], 1'b0};
                        end
                    end
                    else if (is_master && xfer_start_i)
                    begin
                        sel     <= xfer_ss_i;
                        dir_out <= xfer_dir_out_i;
                        last    <= xfer_last_i;
                        sh_tx   <= tx_data_i;
                        ss_n    <= ~(4'h1 << xfer_ss_i);
                        tcnt    <= 10'h000;
                        state   <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    tcnt <= tcnt + 10'h001;
                    if (tcnt == `UBSP_SS_SETUP - 1)  // [RQ19]
                    begin
                        state <= ST_BITS;
                        hcnt  <= 9'h000;
                        bcnt  <= 4'h0;
                        phase <= 1'b0;
                    end
                end
                ST_BITS:
                begin
                    hcnt <= hcnt + 9'h001;
                    if (hcnt == half - 9'h001)
                    begin
                        hcnt  <= 9'h000;
                        phase <= ~phase;
                        sck_o <= ~sck_o;
                        if (phase == cpha)  // [RQ22] sample edge
                        begin
                            case (width)
                                `UBSP_W_DUAL:
                                    sh_rx <= {sh_rx[5:0], io_s[1:0]};
                                `UBSP_W_QUAD:
                                    sh_rx <= {sh_rx[3:0], io_s};
                                default:
                                    sh_rx <= {sh_rx[6:0], io_s[1]};  // [RQ8]
                            endcase
                        end
                        else if (!(cpha && bcnt == 4'h0 && !phase))
                        begin
                            case (width)
                                `UBSP_W_DUAL: sh_tx <= {sh_tx[5:0], 2'h0};
                                `UBSP_W_QUAD: sh_tx <= {sh_tx[3:0], 4'h0};
                                default:      sh_tx <= {sh_tx[6:0], 1'b0};
                            endcase
                        end
                        if (phase)
                        begin
                            bcnt <= bcnt + 4'h1;
                            if (bcnt == steps - 4'h1)
                            begin
                                tcnt        <= 10'h000;
                                state <= last ? ST_HOLD : ST_GAP;
                            end
                        end
                    end
                end
                ST_GAP:
                begin
                    if (tcnt == 10'h000)
                        sh_tx <= tx_data_i;
                    tcnt <= tcnt + 10'h001;
                    if (tcnt == `UBSP_BYTE_GAP - 1)  // [RQ21]
                    begin
                        state <= ST_BITS;
                        bcnt  <= 4'h0;
                        hcnt  <= 9'h000;
                        phase <= 1'b0;
                    end
                end
                ST_HOLD:
                begin
                    tcnt <= tcnt + 10'h001;
                    if (tcnt == `UBSP_SS_HOLD - 1)  // [RQ20]
                    begin
                        ss_n  <= 4'hF;
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // pin muxing and outputs
    // ----------------------------------------
    always @*
    begin
        alt = 4'h0;  // [RQ5]
        case (mode)
            `UBSP_MODE_ONE:   alt = 4'h3;
            `UBSP_MODE_TWO:   alt = 4'hF;
            `UBSP_MODE_THREE: alt = 4'hF;
            default:          alt = is_i2c ? 4'h3 : 4'h0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_mode_o           <= 2'h0;
            data_ifs_o           <= 3'h1;
            gpio_if_o            <= 1'b0;
            func_o               <= 2'h0;
            busy_o               <= 1'b0;
            sck_oe_o             <= 1'b0;
            io_o                 <= 4'h0;
            io_oe_o              <= 4'h0;
            slave_select_out_0_o <= 1'b1;
            gpio_o               <= 4'h0;
            gpio_oe_o            <= 4'h0;
            gpio_in_o            <= 4'h0;
        end
        else
        begin
            cfg_mode_o <= mode;
            case (mode)  // [RQ2]
                `UBSP_MODE_ZERO: data_ifs_o <= 3'h1;
                `UBSP_MODE_ONE:  data_ifs_o <= 3'h3;
                `UBSP_MODE_TWO:  data_ifs_o <= 3'h4;
                default:         data_ifs_o <= 3'h1;
            endcase
            gpio_if_o <= (mode == `UBSP_MODE_ZERO) ||
                         (mode == `UBSP_MODE_ONE);
            func_o    <= func;
            busy_o    <= (state != ST_IDLE);
            sck_oe_o  <= is_master;
            slave_select_out_0_o <= ss_n[0];
            // data line direction
            if (is_master)
            begin
                case (width)
                    `UBSP_W_DUAL:
                    begin
                        io_o    <= {2'h0, sh_tx[7:6]};
                        io_oe_o <= {2'h0, {2{dir_out}}};
                    end
                    `UBSP_W_QUAD:
                    begin
                        io_o    <= sh_tx[7:4];  // [RQ10]
                        io_oe_o <= {4{dir_out}};
                    end
                    default:
                    begin
                        io_o    <= {3'h0, sh_tx[7]};  // [RQ9] [RQ12]
                        io_oe_o <= 4'h1;
                    end
                endcase
            end
            else if (is_slave && !sss_n)
            begin
                io_o    <= {2'h0, sh_tx[7], 1'b0};  // [RQ8]
                io_oe_o <= 4'h2;
            end
            else
            begin
                io_o    <= 4'h0;
                io_oe_o <= 4'h0;
            end
            // gpio pins: selects replace gpio0..1 in modes 1 and 2, and gpio2 in mode 2 only  [RQ4] [RQ5]
            gpio_in_o <= gpio_s;
            if (mode == `UBSP_MODE_ONE || mode == `UBSP_MODE_TWO)
            begin
                gpio_o[0]    <= ss_n[1];
                gpio_o[1]    <= ss_n[2];
                gpio_oe_o[1:0] <= 2'h3;
            end
            else if (alt[0])
            begin
                gpio_o[1:0]    <= 2'h0;
                gpio_oe_o[1:0] <= 2'h0;
            end
            else
            begin
                gpio_o[1:0]    <= gpio_out_i[1:0];
                gpio_oe_o[1:0] <= gpio_oe_i[1:0];
            end
            if (mode == `UBSP_MODE_TWO)
            begin
                gpio_o[2]    <= ss_n[3];
                gpio_oe_o[2] <= 1'b1;
            end
            else if (alt[2])
            begin
                gpio_o[2]    <= 1'b0;
                gpio_oe_o[2] <= 1'b0;
            end
            else
            begin
                gpio_o[2]    <= gpio_out_i[2];
                gpio_oe_o[2] <= gpio_oe_i[2];
            end
            if (alt[3])
            begin
                gpio_o[3]    <= 1'b0;
                gpio_oe_o[3] <= 1'b0;
            end
            else
            begin
                gpio_o[3]    <= gpio_out_i[3];
                gpio_oe_o[3] <= gpio_oe_i[3];
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/ubsp_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module ubsp_slave_model
(
    input  wire logic       sck_i,
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic [7:0] resp_i,
    output var  logic       miso_o,
    output var  logic [7:0] got_o
);
    logic [7:0] sh;

    initial miso_o = 1'b0;

    always @(negedge ss_n_i)
    begin
        sh = resp_i;
        if (!cpha_i)
            miso_o = sh[7];
    end

    // released line must not keep showing the last bit
    always @(posedge ss_n_i)
        miso_o = ~miso_o;

    always @(sck_i)
    begin
        if (!ss_n_i && ((sck_i != cpol_i) ^ cpha_i))
            got_o = {got_o[6:0], mosi_i};
        else if (!ss_n_i)
        begin
            if (!cpha_i)
                sh = sh << 1;
            miso_o = sh[7];
            if (cpha_i)
                sh = sh << 1;
        end
    end
endmodule
`default_nettype wire

// File: tb/ubsp_port_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubsp_defines.vh"
module ubsp_port_props
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       init_i,
    input wire logic [1:0] init_func_i,
    input wire logic [1:0] init_width_i,
    input wire logic       init_cpol_i,
    input wire logic [3:0] init_exp_i,
    input wire logic [1:0] xfer_ss_i,
    input wire logic       xfer_start_i,
    input wire logic [1:0] cfg_mode_o,
    input wire logic [2:0] data_ifs_o,
    input wire logic [1:0] func_o,
    input wire logic       busy_o,
    input wire logic       sck_o,
    input wire logic [3:0] io_oe_o,
    input wire logic       slave_select_out_0_o,
    input wire logic [3:0] gpio_o
);
    logic       cpol_q;
    logic [1:0] width_q;
    logic [3:0] exp_q;
    logic [9:0] lead;
    logic [9:0] quiet;
    logic       edged;
    logic       sck_d;
    wire  [9:0] half = (exp_q > 4'h8) ? 10'h100 : (10'h001 << exp_q);
    wire        ss_n = slave_select_out_0_o;
    wire        mst = (func_o == `UBSP_FN_MASTER);

    // ----
    // frame timing counters
    // ----
    always_ff @(posedge clk_i)
    begin
        sck_d <= sck_o;
        quiet <= (sck_o != sck_d) ? 10'h000 : quiet + {9'h000, ~&quiet};
        lead  <= ss_n ? 10'h000 : lead + {9'h000, ~&lead};
        edged <= !ss_n && (edged || sck_o != sck_d);
        if (rst_i)
        begin
            quiet   <= 10'h000;
            cpol_q  <= 1'b0;
            width_q <= `UBSP_W_SINGLE;
            exp_q   <= 4'h0;
        end
        else if (init_i && !busy_o)
        begin
            cpol_q  <= init_cpol_i;
            width_q <= init_width_i;
            exp_q   <= init_exp_i;
        end
    end

    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_start;
        xfer_start_i && !busy_o && mst && xfer_ss_i == 2'h0;
    endsequence
    sequence s_sel;
        busy_o && !ss_n;
    endsequence
    sequence s_first;
        $changed(sck_o) && !ss_n && !edged;
    endsequence
    sequence s_trail;
        $changed(sck_o) && !ss_n && sck_o == cpol_q;
    endsequence

    a_start_select: assert property (s_start |-> ##[1:3] s_sel)
        else $error("select late");
    a_select_setup: assert property (s_first |-> lead >= 10'd25)
        else $error("select setup short");
    a_select_hold: assert property (
        $rose(ss_n) && edged |-> quiet >= 10'd880)
        else $error("select hold short");
    a_half_period: assert property (s_trail |-> quiet == half - 10'd1)
        else $error("half period wrong");
    a_idle_level: assert property (
        !busy_o && mst && !init_i && !$past(init_i) && !$past(init_i, 2)
        |-> sck_o == cpol_q)
        else $error("idle level wrong");
    a_mode_ifs: assert property (
        ($stable(cfg_mode_o))[*2] |-> data_ifs_o == ((cfg_mode_o == 2'h1)
        ? 3'h3 : (cfg_mode_o == 2'h2) ? 3'h4 : 3'h1))
        else $error("interface count wrong");
    a_slave_refused: assert property (
        init_i && !busy_o && init_func_i == `UBSP_FN_SLAVE && ^cfg_mode_o
        |-> ##[1:2] func_o == `UBSP_FN_NONE)
        else $error("slave not refused");
    a_quad_pins: assert property (
        (busy_o && width_q != `UBSP_W_QUAD) || func_o == `UBSP_FN_SLAVE
        |-> io_oe_o[3:2] == 2'h0)
        else $error("quad pins driven");
    a_gpio_alt: assert property (
        cfg_mode_o == 2'h2 && mst && !busy_o |-> gpio_o[2:0] == 3'h7)
        else $error("gpio overrides select");
endmodule

bind ubsp_port ubsp_port_props u_props
(
    .clk_i(clk_i), .rst_i(rst_i), .init_i(init_i), .init_func_i(init_func_i),
    .init_width_i(init_width_i), .init_cpol_i(init_cpol_i),
    .init_exp_i(init_exp_i), .xfer_ss_i(xfer_ss_i),
    .xfer_start_i(xfer_start_i), .cfg_mode_o(cfg_mode_o),
    .data_ifs_o(data_ifs_o), .func_o(func_o), .busy_o(busy_o),
    .sck_o(sck_o), .io_oe_o(io_oe_o),
    .slave_select_out_0_o(slave_select_out_0_o), .gpio_o(gpio_o)
);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubsp_defines.vh"
module tb_top;
    logic       clk_i, rst_i, strap_hi, strap_lo, init_i, init_cpol_i;
    logic       init_cpha_i, xfer_start_i, xfer_dir_out_i, xfer_last_i;
    logic       sck_pin_i, ss_pin_i, busy_o, byte_done_o, sck_o, ss0_n, m_miso;
    logic [1:0] init_func_i, init_width_i, xfer_ss_i, cfg_mode_o, func_o;
    logic [2:0] data_ifs_o;
    logic [3:0] init_exp_i, gpio_out_i, gpio_oe_i, gpio_pin_i, tb_io;
    logic [3:0] io_o, io_oe_o, gpio_o, io_w;
    logic [7:0] tx_data_i, rx_data_o, m_resp, m_got;
    int         n_errors, n_checks;

    // wire level: DUT drives where io_oe_o is set, else model and tb drive
    assign io_w = (io_oe_o & io_o)
                | (~io_oe_o & {tb_io[3:2], m_miso, tb_io[0]});

    ubsp_port u_dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_strap_hi_i(strap_hi),
        .cfg_strap_lo_i(strap_lo), .init_i(init_i), .init_func_i(init_func_i),
        .init_width_i(init_width_i), .init_cpol_i(init_cpol_i),
        .init_cpha_i(init_cpha_i), .init_exp_i(init_exp_i),
        .xfer_ss_i(xfer_ss_i), .xfer_start_i(xfer_start_i),
        .xfer_dir_out_i(xfer_dir_out_i), .xfer_last_i(xfer_last_i),
        .tx_data_i(tx_data_i), .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i),
        .gpio_pin_i(gpio_pin_i), .sck_pin_i(sck_pin_i), .ss_pin_i(ss_pin_i),
        .io_pin_i(io_w), .cfg_mode_o(cfg_mode_o), .data_ifs_o(data_ifs_o),
        .gpio_if_o(), .func_o(func_o), .busy_o(busy_o),
        .byte_done_o(byte_done_o), .rx_data_o(rx_data_o), .gpio_in_o(),
        .sck_o(sck_o), .sck_oe_o(), .io_o(io_o), .io_oe_o(io_oe_o),
        .slave_select_out_0_o(ss0_n), .gpio_o(gpio_o), .gpio_oe_o()
    );

    ubsp_slave_model u_slave
    (
        .sck_i(sck_o), .ss_n_i(ss0_n), .mosi_i(io_w[0]), .cpol_i(init_cpol_i),
        .cpha_i(init_cpha_i), .resp_i(m_resp), .miso_o(m_miso), .got_o(m_got)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rst_to(input logic [1:0] m);
        @(posedge clk_i);
        rst_i    <= 1'b1;
        strap_hi <= m[1];
        strap_lo <= m[0];
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic ini(input logic [1:0] f, w, input logic pol, pha);
        @(posedge clk_i);
        init_i       <= 1'b1;
        init_func_i  <= f;
        init_width_i <= w;
        init_cpol_i  <= pol;
        init_cpha_i  <= pha;
        @(posedge clk_i);
        init_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic xfer(input logic [7:0] d, output logic [7:0] rx);
        int n;
        @(posedge clk_i);
        xfer_start_i <= 1'b1;
        tx_data_i    <= d;
        @(posedge clk_i);
        xfer_start_i <= 1'b0;
        for (n = 0; n < 9000 && byte_done_o !== 1'b1; n++) @(negedge clk_i);
        rx = rx_data_o;
        for (n = 0; n < 9000 && busy_o !== 1'b0; n++) @(negedge clk_i);
        chk(8'(busy_o), 8'h00);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            rst_to(m[1:0]);
            chk(8'(func_o), 8'(`UBSP_FN_NONE));
            chk(8'(cfg_mode_o), 8'(m));
            chk(8'(data_ifs_o), m == 1 ? 8'h03 : m == 2 ? 8'h04 : 8'h01);
            ini(`UBSP_FN_SLAVE, `UBSP_W_SINGLE, 1'b0, 1'b0);
            chk(8'(func_o), (m == 1 || m == 2) ? 8'h00 : 8'h02);
            ini(`UBSP_FN_MASTER, `UBSP_W_SINGLE, 1'b0, 1'b0);
            chk(8'(func_o), 8'(`UBSP_FN_MASTER));
            if (m == 0)
                chk(8'(gpio_o[1:0]), 8'h01);
            if (m == 1)
                chk(8'(gpio_o[1:0]), 8'h03);
            if (m == 2)
                chk(8'(gpio_o[2:0]), 8'h07);
        end
    endtask

    task automatic t_single();
        logic [7:0] rx;
        for (int i = 0; i < 4; i++)
        begin
            init_exp_i <= 4'(i + 2);
            m_resp     <= 8'h3C + 8'(i);
            ini(`UBSP_FN_MASTER, `UBSP_W_SINGLE, i[1], i[0]);
            xfer(8'hA5 - 8'(i), rx);
            chk(rx, 8'h3C + 8'(i));
            chk(m_got, 8'hA5 - 8'(i));
            chk(8'(sck_o), 8'(i[1]));
        end
    endtask

    task automatic t_wide();
        logic [7:0] acc, rx, oe;
        for (int w = 1; w < 3; w++)
        begin
            init_exp_i <= 4'hF;
            ini(`UBSP_FN_MASTER, w[1:0], 1'b0, 1'b0);
            fork
                xfer(8'h96, rx);
                repeat (w == 1 ? 4 : 2)
                begin
                    @(posedge sck_o);
                    acc = (w == 1) ? {acc[5:0], io_o[1:0]} : {acc[3:0], io_o};
                    oe  = 8'(io_oe_o);
                end
            join
            chk(acc, 8'h96);
            chk(oe, (w == 1) ? 8'h03 : 8'h0F);
        end
    endtask

    task automatic t_slave();
        logic [7:0] d, so;
        d = 8'h5A;
        ini(`UBSP_FN_SLAVE, `UBSP_W_SINGLE, 1'b0, 1'b0);
        tx_data_i <= 8'hC3;
        ss_pin_i  <= 1'b0;
        repeat (10) @(posedge clk_i);
        for (int b = 7; b >= 0; b--)
        begin
            tb_io[0] <= d[b];
            repeat (5) @(posedge clk_i);
            sck_pin_i <= 1'b1;
            so = {so[6:0], io_w[1]};
            repeat (5) @(posedge clk_i);
            sck_pin_i <= 1'b0;
        end
        repeat (10) @(posedge clk_i);
        ss_pin_i <= 1'b1;
        tb_io[0] <= ~tb_io[0];
        chk(rx_data_o, d);
        chk(so, 8'hC3);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        rst_i = 1'b1;
        {strap_hi, strap_lo, init_i, init_cpol_i, init_cpha_i, sck_pin_i} = 6'h00;
        {init_func_i, init_width_i, xfer_ss_i} = 6'h00;
        {xfer_start_i, xfer_dir_out_i, xfer_last_i, ss_pin_i} = 4'h7;
        {init_exp_i, gpio_pin_i, tb_io} = 12'h000;
        gpio_out_i = 4'h5;
        gpio_oe_i  = 4'hF;
        tx_data_i  = 8'h00;
        m_resp     = 8'h00;
        n_errors   = 0;
        n_checks   = 0;
        t_modes();
        t_single();
        t_wide();
        t_slave();
        tally_and_finish();
    end

    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
